/* File: hw/scf_regs.svh */
// Purpose: named offsets, fields, reset values and counts for the flow control block
// Assumes: included by the package and by every design file
// Notes: definitions only
`ifndef SCF_REGS_SVH
`define SCF_REGS_SVH
`define SCF_RESET_ADDR 12'h000
`define SCF_ADDR_ONE 12'h001
`define SCF_INT_VECTOR_DFLT 12'h3FF
`define SCF_INSTR_CYCLES 2
`define SCF_STACK_FULL 5'h1E
`define SCF_STACK_EMPTY 5'h00
`define SCF_DEPTH_ONE 5'h01
`define SCF_OPC_MSB 17
`define SCF_OPC_LSB 12
`define SCF_OPD_BIT 0
`define SCF_OPC_JUMP 6'h22
`define SCF_OPC_INTCTL 6'h28
`define SCF_OPC_RETI 6'h29
`define SCF_OFF_CTRL 12'h000
`define SCF_OFF_STATUS 12'h004
`define SCF_OFF_FAULT 12'h008
`define SCF_CTRL_SRST 0
`define SCF_FAULT_OVF 0
`define SCF_FAULT_UNF 1
`define SCF_ST_PC_MSB 11
`define SCF_ST_C 12
`define SCF_ST_Z 13
`define SCF_ST_B 14
`define SCF_ST_INT_EN 15
`define SCF_ST_DEP_LSB 16
`define SCF_ST_DEP_MSB 20
`define SCF_ZERO32 32'h0000_0000
`endif

/* File: hw/scf_pkg.sv */
// Purpose: shared types of the flow control block
// Assumes: widths fixed at the documented values
// Notes: constants live in scf_regs.svh
`include "scf_regs.svh"
package scf_pkg;
    // instruction phase, one-hot
    typedef enum logic [1:0] {
        SCF_PH_FETCH = 2'b01,
        SCF_PH_EXEC = 2'b10
    } scf_phase_t;
    // decoded operation class, one-hot
    typedef enum logic [3:0] {
        SCF_OP_SEQ = 4'b0001,
        SCF_OP_JUMP = 4'b0010,
        SCF_OP_INTCTL = 4'b0100,
        SCF_OP_RETI = 4'b1000
    } scf_op_t;
    // one call-stack entry
    typedef struct packed {
        logic bank;
        logic zero;
        logic carry;
        logic [11:0] addr;
    } scf_frame_t;
    // decoded instruction
    typedef struct packed {
        scf_op_t op;
        logic opd;
        logic [11:0] target;
    } scf_dec_t;
    // stack state
    typedef struct packed {
        logic [4:0] depth;
    } scf_stk_st_t;
    // controller state
    typedef struct packed {
        scf_phase_t phase;
        logic [11:0] pc;
        logic carry;
        logic zero;
        logic bank;
        logic int_en;
        logic int_ack;
        logic rst_evt;
        logic ovf_seen;
        logic unf_seen;
        logic [31:0] prdata;
        logic pslverr;
    } scf_ctrl_st_t;
endpackage

/* File: hw/scf_stack.sv */
// Purpose: 30-level call stack holding return frames
// Assumes: push and pop never asked in one cycle
// Notes: a refused push or pop is reported, never performed
`timescale 1ns/100ps
`include "scf_regs.svh"
module scf_stack import scf_pkg::*; (
    input wire logic clk, // core clock
    input wire logic clr, // synchronous clear
    input wire logic push, // store a frame
    input wire logic pop, // drop the top frame
    input wire scf_frame_t din, // frame to store
    output scf_frame_t top, // most recent frame
    output logic [4:0] depth, // levels in use
    output logic ovf, // push while full
    output logic unf // pop while empty
);
    scf_stk_st_t s_r; // registered state
    scf_stk_st_t s_nxt; // next state
    scf_frame_t mem [0:29]; // frame storage

    // depth bookkeeping and fault detection
    always_comb begin
        s_nxt = s_r;
        ovf = push && (s_r.depth == `SCF_STACK_FULL);
        unf = pop && (s_r.depth == `SCF_STACK_EMPTY);
        if (clr) begin
            s_nxt.depth = `SCF_STACK_EMPTY;
        end else if (push && !ovf) begin
            s_nxt.depth = 5'(s_r.depth + `SCF_DEPTH_ONE);
        end else if (pop && !unf) begin
            s_nxt.depth = 5'(s_r.depth - `SCF_DEPTH_ONE);
        end
    end

    // state and storage
    always_ff @(posedge clk) begin
        s_r <= s_nxt;
        if (push && !ovf && !clr) begin
            mem[s_r.depth] <= din;
        end
    end

    // empty stack shows a zero frame
    assign top = (s_r.depth == `SCF_STACK_EMPTY) ? '0 :
        mem[5'(s_r.depth - `SCF_DEPTH_ONE)];
    assign depth = s_r.depth;
endmodule

/* File: hw/scf_decode.sv */
// Purpose: splits an instruction word into operation, operand and target
// Assumes: opcode in the top six bits, address in the low twelve
// Notes: anything unknown advances like an ordinary instruction
`timescale 1ns/100ps
`include "scf_regs.svh"
module scf_decode import scf_pkg::*; (
    input wire logic [17:0] instr, // instruction word
    output scf_dec_t dec // decoded fields
);
    // one decode shared by all users
    function automatic scf_dec_t scf_dec_f(input logic [17:0] w);
        scf_dec_t d;
        d.opd = w[`SCF_OPD_BIT];
        d.target = w[11:0];
        unique case (w[`SCF_OPC_MSB:`SCF_OPC_LSB])
            `SCF_OPC_JUMP: d.op = SCF_OP_JUMP;
            `SCF_OPC_INTCTL: d.op = SCF_OP_INTCTL;
            `SCF_OPC_RETI: d.op = SCF_OP_RETI;
            default: d.op = SCF_OP_SEQ;
        endcase
        return d;
    endfunction

    // purely combinational
    always_comb begin
        dec = scf_dec_f(instr);
    end
endmodule

/* File: hw/scf_ctrl.sv */
// Purpose: interrupt entry, interrupt return and jump control of a small core
// Assumes: single clock, synchronous active-high reset, inputs synchronous
// Notes: instruction word is sampled in the second cycle of each instruction
//
// Contract
// RL1 - interrupt abandons instruction, pushes address, vectors
// RL2 - entry pushes flags, bank; clears enable
// RL3 - enabled and request high means interrupt taken
// RL4 - return pops address into program counter
// RL5 - return restores carry, zero and bank
// RL6 - return operand sets or clears enable
// RL7 - stack holds 30 levels, interrupt uses one
// RL8 - overflow on entry forces internal reset
// RL9 - return on empty stack forces reset
// RL10 - every instruction takes two clock cycles
// RL11 - redundant enable or disable is harmless
// RL12 - jump loads target, touches nothing else
// RL13 - start at zero, else advance by one
// RL14 - program addresses are twelve bits wide
// RL15 - integrator fits program in fitted memory
// RL16 - reset leaves interrupts disabled
// RL17 - request ignored while enable clear
// RL18 - enable sets flag, disable clears it
// RL19 - vector fixed by build parameter
// RL20 - stack entry holds address, flags, bank
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "scf_regs.svh"
module scf_ctrl import scf_pkg::*; #(
    parameter logic [11:0] INT_VECTOR = `SCF_INT_VECTOR_DFLT // [RL19]
) (
    input wire logic CORE_CLK, // core clock, 40 MHz
    input wire logic RST, // synchronous reset, high
    input wire logic [17:0] INSTRUCTION, // current instruction word
    input wire logic INTERRUPT, // interrupt request, high
    input wire logic ALU_FLAG_WE, // alu updates carry and zero
    input wire logic ALU_CARRY, // new carry from alu
    input wire logic ALU_ZERO, // new zero from alu
    input wire logic BANK_WE, // bank select instruction
    input wire logic BANK_IN, // new bank selection
    output logic [11:0] ADDRESS, // program counter
    output logic CARRY_FLAG, // carry flag
    output logic ZERO_FLAG, // zero flag
    output logic BANK_SEL, // active register bank
    output logic INTERRUPT_ENABLE_FLAG, // interrupt enable flag
    output logic EXEC_PHASE, // second cycle of instruction
    output logic INT_ACK, // interrupt taken pulse
    output logic INTERNAL_RESET, // self reset pulse
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR // apb error
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    scf_ctrl_st_t s_r; // registered state
    scf_ctrl_st_t s_nxt; // next state
    scf_dec_t dec; // decoded instruction
    scf_frame_t stk_din; // frame to push
    scf_frame_t stk_top; // most recent frame
    logic [4:0] stk_depth; // levels in use
    logic stk_push; // push request
    logic stk_pop; // pop request
    logic stk_ovf; // push refused
    logic stk_unf; // pop refused
    logic stk_clr; // clear stack
    logic exec; // commit cycle
    logic take; // interrupt accepted now
    logic soft_rst; // software reset write
    logic fault; // any self reset cause
    logic apb_wr; // write takes effect
    logic apb_setup; // first apb cycle

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // address advance wraps inside the twelve-bit space
    function automatic logic [11:0] scf_next_addr(input logic [11:0] a);
        return 12'(a + `SCF_ADDR_ONE); // [RL14]
    endfunction

    // apb address match
    function automatic logic scf_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // submodules
    scf_decode u_dec (
        .instr(INSTRUCTION),
        .dec(dec)
    );

    scf_stack u_stk (
        .clk(CORE_CLK),
        .clr(stk_clr),
        .push(stk_push),
        .pop(stk_pop),
        .din(stk_din),
        .top(stk_top),
        .depth(stk_depth),
        .ovf(stk_ovf),
        .unf(stk_unf)
    );

    ////////////////////////////////////////////////////////////////////////
    // control terms
    assign exec = (s_r.phase == SCF_PH_EXEC);
    // only an enabled core sees the request
    assign take = exec && s_r.int_en && INTERRUPT; // [RL3] [RL17]
    assign stk_push = take; // [RL7]
    assign stk_pop = exec && !take && (dec.op == SCF_OP_RETI);
    // frame carries address, flags and bank
    assign stk_din = '{bank: s_r.bank, zero: s_r.zero,
        carry: s_r.carry, addr: s_r.pc}; // [RL2] [RL20]
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign soft_rst = apb_wr && scf_hit(PADDR, `SCF_OFF_CTRL)
        && PWDATA[`SCF_CTRL_SRST];
    assign fault = stk_ovf || stk_unf || soft_rst; // [RL8] [RL9]
    // stack empties with the internal reset
    assign stk_clr = RST || fault;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.int_ack = 1'b0;
        s_nxt.rst_evt = 1'b0;
        // two phases per instruction, no stall
        unique case (s_r.phase)
            SCF_PH_FETCH: begin
                s_nxt.phase = SCF_PH_EXEC; // [RL10]
            end
            SCF_PH_EXEC: begin
                s_nxt.phase = SCF_PH_FETCH; // [RL10]
                if (take) begin
                    // current instruction is dropped, its address saved
                    s_nxt.pc = INT_VECTOR; // [RL1] [RL19]
                    s_nxt.int_en = 1'b0; // [RL2]
                    s_nxt.int_ack = 1'b1;
                end else begin
                    unique case (dec.op)
                        SCF_OP_JUMP: begin
                            // flags and bank left untouched
                            s_nxt.pc = dec.target; // [RL12]
                        end
                        SCF_OP_INTCTL: begin
                            // same value again simply rewrites it
                            s_nxt.int_en = dec.opd; // [RL18] [RL11]
                            s_nxt.pc = scf_next_addr(s_r.pc); // [RL13]
                        end
                        SCF_OP_RETI: begin
                            // resume the abandoned instruction
                            s_nxt.pc = stk_top.addr; // [RL4]
                            s_nxt.carry = stk_top.carry; // [RL5]
                            s_nxt.zero = stk_top.zero; // [RL5]
                            s_nxt.bank = stk_top.bank; // [RL5]
                            s_nxt.int_en = dec.opd; // [RL6]
                        end
                        SCF_OP_SEQ: begin
                            s_nxt.pc = scf_next_addr(s_r.pc); // [RL13]
                            if (ALU_FLAG_WE) begin
                                s_nxt.carry = ALU_CARRY;
                                s_nxt.zero = ALU_ZERO;
                            end
                            if (BANK_WE) begin
                                s_nxt.bank = BANK_IN;
                            end
                        end
                    endcase
                end
            end
            default: begin
                // illegal phase code recovers to fetch
                s_nxt.phase = SCF_PH_FETCH;
            end
        endcase
        // self reset: same as RST but keeps bus and fault history
        if (fault) begin
            s_nxt.phase = SCF_PH_FETCH;
            s_nxt.pc = `SCF_RESET_ADDR; // [RL8] [RL9] [RL13]
            s_nxt.carry = 1'b0;
            s_nxt.zero = 1'b0;
            s_nxt.bank = 1'b0;
            s_nxt.int_en = 1'b0; // [RL16]
            s_nxt.int_ack = 1'b0;
            s_nxt.rst_evt = 1'b1;
        end
        // apb: read data and error are latched in the setup cycle
        if (apb_setup) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = `SCF_ZERO32;
            if (scf_hit(PADDR, `SCF_OFF_STATUS)) begin
                s_nxt.prdata[`SCF_ST_PC_MSB:0] = s_r.pc;
                s_nxt.prdata[`SCF_ST_C] = s_r.carry;
                s_nxt.prdata[`SCF_ST_Z] = s_r.zero;
                s_nxt.prdata[`SCF_ST_B] = s_r.bank;
                s_nxt.prdata[`SCF_ST_INT_EN] = s_r.int_en;
                s_nxt.prdata[`SCF_ST_DEP_MSB:`SCF_ST_DEP_LSB] = stk_depth;
            end else if (scf_hit(PADDR, `SCF_OFF_FAULT)) begin
                s_nxt.prdata[`SCF_FAULT_OVF] = s_r.ovf_seen;
                s_nxt.prdata[`SCF_FAULT_UNF] = s_r.unf_seen;
            end else if (!scf_hit(PADDR, `SCF_OFF_CTRL)) begin
                // unmapped address
                s_nxt.pslverr = 1'b1;
            end
        end
        // fault history: write one clears, a new fault wins
        if (apb_wr && scf_hit(PADDR, `SCF_OFF_FAULT)) begin
            if (PWDATA[`SCF_FAULT_OVF]) begin
                s_nxt.ovf_seen = 1'b0;
            end
            if (PWDATA[`SCF_FAULT_UNF]) begin
                s_nxt.unf_seen = 1'b0;
            end
        end
        if (stk_ovf) begin
            s_nxt.ovf_seen = 1'b1;
        end
        if (stk_unf) begin
            s_nxt.unf_seen = 1'b1;
        end
        // external reset overrides everything
        if (RST) begin
            s_nxt = '0;
            s_nxt.phase = SCF_PH_FETCH;
            s_nxt.pc = `SCF_RESET_ADDR; // [RL13]
            s_nxt.int_en = 1'b0; // [RL16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CORE_CLK) begin
        s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign ADDRESS = s_r.pc;
    assign CARRY_FLAG = s_r.carry;
    assign ZERO_FLAG = s_r.zero;
    assign BANK_SEL = s_r.bank;
    assign INTERRUPT_ENABLE_FLAG = s_r.int_en;
    assign EXEC_PHASE = exec;
    assign INT_ACK = s_r.int_ack;
    assign INTERNAL_RESET = s_r.rst_evt;
    assign PRDATA = s_r.prdata;
    // zero wait states: data latched at the end of setup is ready in the access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && s_r.pslverr;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    sequence two_phase_s;
        s_r.phase == SCF_PH_EXEC ##1 s_r.phase == SCF_PH_FETCH;
    endsequence

    sequence entry_done_s;
        s_r.pc == INT_VECTOR && INT_ACK && !s_r.int_en;
    endsequence

    // interrupt entry vectors and disables
    irq_entry_a: assert property ( // [RL1]
        (take && !soft_rst && stk_depth != `SCF_STACK_FULL) |=> entry_done_s)
        else $error("interrupt entry did not vector");

    // frame pushed holds address, flags and bank
    irq_frame_a: assert property ( // [RL2]
        (take && !soft_rst && stk_depth != `SCF_STACK_FULL)
        |=> stk_top == $past(stk_din) && stk_depth == $past(stk_depth) + 5'h01)
        else $error("saved frame wrong");

    // disabled core never acknowledges
    irq_masked_a: assert property ( // [RL17]
        !s_r.int_en |=> !INT_ACK)
        else $error("interrupt taken while disabled");

    // return restores address and flags
    reti_restore_a: assert property ( // [RL4]
        (stk_pop && stk_depth != `SCF_STACK_EMPTY && !soft_rst)
        |=> s_r.pc == $past(stk_top.addr) && s_r.carry == $past(stk_top.carry)
            && s_r.zero == $past(stk_top.zero) && s_r.bank == $past(stk_top.bank))
        else $error("return restored wrong state");

    // return operand decides enable
    reti_enable_a: assert property ( // [RL6]
        (stk_pop && stk_depth != `SCF_STACK_EMPTY && !soft_rst)
        |=> s_r.int_en == $past(dec.opd))
        else $error("return enable wrong");

    // overflow forces self reset
    ovf_reset_a: assert property ( // [RL8]
        (take && stk_depth == `SCF_STACK_FULL)
        |=> INTERNAL_RESET && s_r.pc == `SCF_RESET_ADDR && stk_depth == `SCF_STACK_EMPTY
            ##1 !INTERNAL_RESET)
        else $error("overflow did not reset");

    // underflow forces self reset
    unf_reset_a: assert property ( // [RL9]
        (stk_pop && stk_depth == `SCF_STACK_EMPTY)
        |=> INTERNAL_RESET && s_r.pc == `SCF_RESET_ADDR && !s_r.int_en)
        else $error("underflow did not reset");

    // fetch then exec, strictly alternating; a self reset restarts the pair
    two_cycle_a: assert property ( // [RL10]
        (s_r.phase == SCF_PH_FETCH && !fault) |=> two_phase_s)
        else $error("instruction not two cycles");

    // jump changes only the program counter
    jump_only_a: assert property ( // [RL12]
        (exec && !take && !fault && dec.op == SCF_OP_JUMP)
        |=> s_r.pc == $past(dec.target) && $stable(s_r.carry) && $stable(s_r.zero)
            && $stable(s_r.bank) && $stable(s_r.int_en))
        else $error("jump disturbed state");

    // ordinary instruction advances by one
    pc_step_a: assert property ( // [RL13]
        (exec && !take && !fault && dec.op == SCF_OP_SEQ)
        |=> s_r.pc == 12'($past(s_r.pc) + 12'h001) ##1 $stable(s_r.pc))
        else $error("program counter did not advance");

    // after reset: address zero, interrupts off
    reset_start_a: assert property ( // [RL16]
        $past(RST) |-> s_r.pc == `SCF_RESET_ADDR && !s_r.int_en)
        else $error("reset state wrong");

    // enable control writes exactly its operand
    int_ctl_a: assert property ( // [RL18]
        (exec && !take && !fault && dec.op == SCF_OP_INTCTL)
        |=> s_r.int_en == $past(dec.opd) && $stable(s_r.carry) && $stable(s_r.bank))
        else $error("enable control wrong");
endmodule

/* File: testbench/scf_irq_src.sv */
// Purpose: stand-in for the user logic that raises the interrupt request
// Assumes: request is a level, taken by the core only while enabled
// Notes: an unserviced request stays up until the core acknowledges it
`timescale 1ns/100ps
module scf_irq_src (
    input wire logic clk, // core clock
    input wire logic rst, // synchronous reset, high
    input wire logic raise, // bench asks for an interrupt
    input wire logic ack, // core took the interrupt
    output logic irq // request level to the core
);
    logic pend_r; // request still waiting for service
    ////////////////////////////////////////////////////////////////
    // prompt answer: the level follows raise in the same cycle
    assign irq = raise | pend_r;
    // held like a real source: ignoring it does not make it go away
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= (pend_r | raise) & ~ack;
        end
    end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for interrupt entry, return and jumps
// Assumes: an instruction is driven for the execute cycle only
// Notes: the core never idles, so bus reads park it on a self jump
`timescale 1ns/100ps
module tb_top;
    localparam logic [11:0] VEC = 12'h2A5; // vector inside the 4K space
    logic clk = 1'b0; // core clock
    logic rst = 1'b1; // reset, high
    logic [17:0] instr = 18'h00000; // instruction word
    logic [4:0] side = 5'h00; // flag we, carry, zero, bank we, bank
    logic raise = 1'b0; // asks the source for an interrupt
    logic psel = 1'b0; // bus select
    logic pen = 1'b0; // bus enable
    logic pwr = 1'b0; // bus direction
    logic [11:0] paddr = 12'h000; // bus address
    logic [31:0] pwdata = 32'h0000_0000; // bus write data
    logic [31:0] prdata; // bus read data
    logic [11:0] address; // program counter
    logic irq, cf, zf, bs, enf, ex, ack, irst, pready, pslverr; // source request and core outputs
    logic [31:0] core; // flags and pc in status layout
    int n_mismatch = 0; // mismatches seen
    int n_tests = 0; // comparisons made
    assign core = {16'h0000, enf, bs, zf, cf, address};
    ////////////////////////////////////////////////////////////////
    scf_ctrl #(.INT_VECTOR(VEC)) dut (.CORE_CLK(clk), .RST(rst), .INSTRUCTION(instr),
        .INTERRUPT(irq), .ALU_FLAG_WE(side[4]), .ALU_CARRY(side[3]), .ALU_ZERO(side[2]),
        .BANK_WE(side[1]), .BANK_IN(side[0]), .ADDRESS(address), .CARRY_FLAG(cf),
        .ZERO_FLAG(zf), .BANK_SEL(bs), .INTERRUPT_ENABLE_FLAG(enf), .EXEC_PHASE(ex),
        .INT_ACK(ack), .INTERNAL_RESET(irst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    scf_irq_src src (.clk(clk), .rst(rst), .raise(raise), .ack(ack), .irq(irq));
    // 40 MHz core clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one instruction: entered and left at a fetch-cycle falling edge
    task op(input logic [17:0] i, input logic [4:0] s, input logic r);
        @(posedge clk);
        instr <= i;
        side <= s;
        raise <= r;
        @(posedge clk);
        raise <= 1'b0;
        @(negedge clk);
    endtask
    // realign to a fetch cycle after bus traffic or a self reset
    task sync;
        @(negedge clk);
        // a stuck phase is caught by the bench timeout
        while (ex !== 1'b1) begin
            @(negedge clk);
        end
        @(negedge clk);
    endtask
    // park on a harmless self jump, so a faulting word is not replayed
    task recover;
        @(posedge clk);
        instr <= 18'h22000;
        sync;
    endtask
    // one bus transfer; r holds {error, read data}
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // held until ready is seen at a rising edge; only the timeout ends the wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // status read with the core parked at p
    task stat(input logic [11:0] p, input logic [11:0] a, output logic [32:0] r);
        op({6'h22, p}, 5'h00, 1'b0);
        apb(1'b0, a, 32'h0000_0000, r);
        sync;
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // sequencing, timing, jumps and address wrap
    task t_seq;
        time t0;
        op(18'h22100, 5'h1B, 1'b0);
        check(core, 32'h0000_0100);
        op(18'h00000, 5'h1B, 1'b0);
        op(18'h22200, 5'h00, 1'b0);
        check(core, 32'h0000_5200);
        t0 = $time;
        repeat (3) op(18'h00000, 5'h00, 1'b0);
        check(32'(($time - t0) / 25), 32'h6);
        check(core, 32'h0000_5203);
        check(ex, 1'b0);
        op(18'h22FFF, 5'h00, 1'b0);
        op(18'h00000, 5'h00, 1'b0);
        check(core, 32'h0000_5000);
        op(18'h22200, 5'h00, 1'b0);
    endtask
    // enable control, interrupt entry and both kinds of return
    task t_irq;
        logic [32:0] r;
        op(18'h28000, 5'h00, 1'b0);
        check(core, 32'h0000_5201);
        op(18'h00000, 5'h00, 1'b1);
        check({ack, core}, 33'h0_0000_5202);
        op(18'h28001, 5'h00, 1'b0);
        check(core, 32'h0000_D203);
        op(18'h22555, 5'h04, 1'b0);
        check({ack, core}, {17'h1_0000, 4'h5, VEC});
        stat(VEC, 12'h004, r);
        check(r, {12'h000, 5'h01, 4'h5, VEC});
        op(18'h00000, 5'h16, 1'b0);
        op(18'h29001, 5'h00, 1'b0);
        check(core, 32'h0000_D203);
        op(18'h00000, 5'h16, 1'b1);
        check(core, {20'h0000_5, VEC});
        op(18'h29000, 5'h00, 1'b0);
        check(core, 32'h0000_5203);
        op(18'h28001, 5'h00, 1'b0);
        op(18'h28001, 5'h00, 1'b0);
        check(core, 32'h0000_D205);
        op(18'h28000, 5'h00, 1'b0);
        check(core, 32'h0000_5206);
    endtask
    // return on an empty stack, fault record and an unmapped register
    task t_unf;
        logic [32:0] r;
        op(18'h29001, 5'h00, 1'b0);
        check({irst, core}, 33'h1_0000_0000);
        recover;
        apb(1'b0, 12'h008, 32'h0000_0000, r);
        check(r, 33'h0_0000_0002);
        apb(1'b1, 12'h008, 32'h0000_0002, r);
        apb(1'b0, 12'h008, 32'h0000_0000, r);
        check(r, 33'h0_0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000, r);
        check(r, 33'h1_0000_0000);
        sync;
        // software reset write acts like a fault but leaves no fault record
        op(18'h220F0, 5'h00, 1'b0);
        apb(1'b1, 12'h000, 32'h0000_0001, r);
        @(negedge clk);
        check({irst, core}, 33'h1_0000_0000);
    endtask
    // thirty nested interrupts fill the stack, the next one overflows
    task t_ovf;
        logic [32:0] r;
        for (int k = 0; k < 30; k++) begin
            op(18'h28001, 5'h00, 1'b0);
            op(18'h00000, 5'h00, 1'b1);
        end
        stat(VEC, 12'h004, r);
        check(r, {12'h001, 8'hE0, VEC});
        op(18'h28001, 5'h00, 1'b0);
        op(18'h00000, 5'h00, 1'b1);
        check({irst, core}, 33'h1_0000_0000);
        recover;
        stat(12'h000, 12'h008, r);
        check(r, 33'h0_0000_0001);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(core, 32'h0000_0000);
        sync;
        t_seq;
        t_irq;
        t_unf;
        t_ovf;
        stop_test;
    end
    // a hang counts as a mismatch and ends the run
    initial begin
        int c;
        c = 0;
        forever begin
            @(posedge clk);
            c++;
            if (c == 5000) begin
                n_mismatch++;
                stop_test;
            end
        end
    end
endmodule
